// ==== rtl/ais_top.sv ====
// analog input image with wishbone register access
`timescale 1ns/1ps
`default_nettype none
module ais_top #(
    parameter int                       ADR_W       = 6,
    parameter logic signed [15:0]       NORM_HI     = 16'sh7000,
    parameter logic signed [15:0]       FULL_HI     = 16'sh7FFF,
    parameter logic signed [15:0]       FULL_LO_BI  = 16'sh8000,
    parameter logic signed [15:0]       FULL_LO_UNI = 16'shF000
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [ADR_W-1:0]       wb_adr_i,
    input  wire logic [31:0]            wb_dat_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic                   wb_we_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    output logic                        wb_err_o,
    input  wire ais_pkg::ais_conv_t     conv_i,
    output ais_pkg::ais_chcfg_t [3:0]   cfg_o
);
    import ais_pkg::*;

    typedef struct packed {
        logic signed [DATA_W-1:0] norm_lo;
        logic signed [DATA_W-1:0] full_lo;
    } ais_limits_t;

    logic [DATA_W-1:0] cfg_reg    [NUM_CHAN];
    logic [DATA_W-1:0] sample_reg [NUM_CHAN];
    logic [NUM_CHAN-1:0] over_reg;
    logic [NUM_CHAN-1:0] under_reg;
    logic [DATA_W-1:0] count_reg;
    logic              ack_reg;
    logic              err_reg;
    logic [31:0]       rdat_reg;

    logic                     req;
    logic [3:0]               idx;
    logic                     hit;
    logic signed [RAW_W-1:0]  raw_s;
    ais_limits_t              lim;
    ais_chcfg_t               ccfg;
    logic                     over_now;
    logic                     under_now;
    logic [DATA_W-1:0]        data_now;

    // lower limits depend on the input type; upper limits are common
    function automatic ais_limits_t limits_of(input logic [3:0] t);
        ais_limits_t l;
        l.norm_lo = 16'sh0000;
        l.full_lo = FULL_LO_UNI;
        if (t == RNG_BIPOLAR_10V) begin
            l.norm_lo = -NORM_HI;
            l.full_lo = FULL_LO_BI;
        end
        return l;
    endfunction

    function automatic ais_chcfg_t unpack_cfg(input logic [DATA_W-1:0] w);
        ais_chcfg_t c;
        c.enable  = w[CFG_EN_BIT];
        c.format  = w[CFG_FMT_LSB +: 3];
        c.in_type = w[CFG_TYPE_LSB +: 4];
        c.filter  = w[CFG_FILT_LSB +: 4];
        return c;
    endfunction

    function automatic logic [DATA_W-1:0] err_word(input logic [NUM_CHAN-1:0] ov,
                                                   input logic [NUM_CHAN-1:0] un);
        logic [DATA_W-1:0] w;
        w = '0;
        w[NUM_CHAN-1:0] = ov | un;
        return w;
    endfunction

    function automatic logic [DATA_W-1:0] range_word(input logic [NUM_CHAN-1:0] ov,
                                                     input logic [NUM_CHAN-1:0] un);
        logic [DATA_W-1:0] w;
        w = '0;
        for (int c = 0; c < NUM_CHAN; c++) begin
            w[OVER_CH0_BIT - FLAG_STRIDE*c]  = ov[c];
            w[UNDER_CH0_BIT - FLAG_STRIDE*c] = un[c];
        end
        return w;
    endfunction

    // bus request decode
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
    assign idx = wb_adr_i[5:2];

    always_comb begin
        hit = 1'b0;
        if (idx <= IDX_COUNT) begin
            hit = 1'b1;
        end
        if (idx >= IDX_CFG0 && idx < IDX_CFG0 + 4'(NUM_CHAN)) begin
            hit = 1'b1;
        end
    end

    // conversion result evaluation for the channel being delivered
    always_comb begin
        ccfg      = unpack_cfg(cfg_reg[conv_i.chan]);
        lim       = limits_of(ccfg.in_type);
        raw_s     = $signed(conv_i.raw);
        over_now  = 1'b0;
        under_now = 1'b0;
        data_now  = raw_s[DATA_W-1:0];
        if (raw_s > RAW_W'(NORM_HI)) begin
            over_now = 1'b1;
        end
        if (raw_s < RAW_W'(lim.norm_lo)) begin
            under_now = 1'b1;
        end
        if (ccfg.in_type == RNG_LOOP_4_20MA && conv_i.open_wire) begin
            under_now = 1'b1;
        end
        if (raw_s > RAW_W'(FULL_HI)) begin
            data_now = FULL_HI;
        end
        if (raw_s < RAW_W'(lim.full_lo) || under_now && conv_i.open_wire) begin
            data_now = lim.full_lo;
        end
        if (over_now && under_now) begin
            over_now = 1'b0;
        end
    end

    // configuration image, byte lane writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                cfg_reg[c] <= CFG_RESET;
            end
        end else if (req && wb_we_i && idx >= IDX_CFG0 && idx < IDX_CFG0 + 4'(NUM_CHAN)) begin
            if (wb_sel_i[0]) begin
                cfg_reg[2'(idx - IDX_CFG0)][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg_reg[2'(idx - IDX_CFG0)][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // data words and range flags move together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                sample_reg[c] <= '0;
            end
            over_reg  <= '0;
            under_reg <= '0;
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                if (!cfg_reg[c][CFG_EN_BIT]) begin
                    sample_reg[c] <= '0;
                    over_reg[c]   <= 1'b0;
                    under_reg[c]  <= 1'b0;
                end else if (conv_i.valid && conv_i.chan == 2'(c)) begin
                    sample_reg[c] <= data_now;
                    over_reg[c]   <= over_now;
                    under_reg[c]  <= under_now;
                end
            end
        end
    end

    // count of conversions taken on enabled channels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (conv_i.valid && ccfg.enable) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // bus answer: ack for mapped words, err otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= req & hit;
            err_reg <= req & ~hit;
        end
    end

    // read data, upper half always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= '0;
        end else if (req) begin
            rdat_reg <= '0;
            if (idx < IDX_ERROR) begin
                rdat_reg[DATA_W-1:0] <= sample_reg[2'(idx)];
            end else if (idx == IDX_ERROR) begin
                rdat_reg[DATA_W-1:0] <= err_word(over_reg, under_reg);
            end else if (idx == IDX_RANGE) begin
                rdat_reg[DATA_W-1:0] <= range_word(over_reg, under_reg);
            end else if (idx == IDX_COUNT) begin
                rdat_reg[DATA_W-1:0] <= count_reg;
            end else if (hit) begin
                rdat_reg[DATA_W-1:0] <= cfg_reg[2'(idx - IDX_CFG0)];
            end
        end
    end

    // configuration fields toward the converter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            for (int c = 0; c < NUM_CHAN; c++) begin
                cfg_o[c] <= unpack_cfg(cfg_reg[c]);
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdat_reg;
endmodule
`default_nettype wire

// ==== rtl/ais_pkg.sv ====
// constants and types for the analog input status image
package ais_pkg;
    localparam int NUM_CHAN    = 4;
    localparam int DATA_W      = 16;
    localparam int RAW_W       = 18;
    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_SAMPLE0 = 4'h0;
    localparam logic [3:0] IDX_ERROR   = 4'h4;
    localparam logic [3:0] IDX_RANGE   = 4'h5;
    localparam logic [3:0] IDX_COUNT   = 4'h6;
    localparam logic [3:0] IDX_CFG0    = 4'h8;
    // configuration word fields
    localparam int CFG_EN_BIT   = 15;
    localparam int CFG_FMT_LSB  = 12;
    localparam int CFG_TYPE_LSB = 8;
    localparam int CFG_FILT_LSB = 0;
    localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
    // status word fields
    localparam int SIGN_BIT        = 15;
    localparam int OVER_CH0_BIT    = 14;
    localparam int UNDER_CH0_BIT   = 15;
    localparam int FLAG_STRIDE     = 2;
    typedef enum logic [3:0] {
        RNG_BIPOLAR_10V = 4'h0,
        RNG_UNI_5V      = 4'h1,
        RNG_UNI_10V     = 4'h2,
        RNG_LOOP_4_20MA = 4'h3,
        RNG_UNI_1_5V    = 4'h4,
        RNG_UNI_0_20MA  = 4'h5
    } ais_range_t;
    typedef struct packed {
        logic             valid;
        logic [1:0]       chan;
        logic [RAW_W-1:0] raw;
        logic             open_wire;
    } ais_conv_t;
    typedef struct packed {
        logic       enable;
        logic [2:0] format;
        logic [3:0] in_type;
        logic [3:0] filter;
    } ais_chcfg_t;
endpackage

// ==== tb/ais_chk.sv ====
// assertion checker for the analog input image
`timescale 1ns/1ps
`default_nettype none
module ais_chk #(
    parameter int ADR_W = 6
) (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic [ADR_W-1:0]         wb_adr_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic                     wb_we_i,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire logic                     wb_err_o,
    input wire ais_pkg::ais_conv_t       conv_i,
    input wire ais_pkg::ais_chcfg_t [3:0] cfg_o
);
    import ais_pkg::*;
    wire logic [3:0] idx = wb_adr_i[5:2];
    wire logic       rd  = wb_ack_o && !wb_we_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ans_lat_a: assert property ($rose(wb_stb_i) |=> wb_ack_o ^ wb_err_o) else $error("answer late");
    unmap_err_a: assert property ($rose(wb_stb_i) && !wb_we_i && (idx == 4'h7 || idx >= 4'hC)
        |=> wb_err_o && wb_dat_o == 32'h0) else $error("unmapped read not refused");
    hi_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper half set");
    err_pad_a: assert property (rd && idx == 4'h4 |-> wb_dat_o[15:4] == 12'h0) else $error("error pad");
    rng_pad_a: assert property (rd && idx == 4'h5 |-> wb_dat_o[7:0] == 8'h0) else $error("range pad");
    cfg_wr_a: assert property (wb_ack_o && wb_we_i && idx == 4'h8 && wb_sel_i == 4'hF
        |=> cfg_o[0] == {$past(wb_dat_i[15:8]), $past(wb_dat_i[3:0])}) else $error("config not written");
    dis_zero_a: assert property (rd && idx == 4'h0 && !cfg_o[0].enable |-> wb_dat_o == 32'h0)
        else $error("disabled channel data");
    rst_val_a: assert property ($fell(rst_i) |-> !wb_ack_o && !wb_err_o && cfg_o == '0)
        else $error("reset values");
    cover property (wb_err_o);
    cover property (wb_ack_o && wb_we_i);
    cover property (conv_i.valid ##1 conv_i.valid);
endmodule
bind ais_top ais_chk #(.ADR_W(ADR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .conv_i(conv_i), .cfg_o(cfg_o));
`default_nettype wire

// ==== tb/ais_fe.sv ====
// analog front end model delivering conversion pulses
`timescale 1ns/1ps
`default_nettype none
module ais_fe (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              go_i,
    input  wire logic [1:0]        chan_i,
    input  wire logic [17:0]       raw_i,
    input  wire logic              open_i,
    output var ais_pkg::ais_conv_t conv_o
);
    import ais_pkg::*;
    // outside a pulse the payload toggles so stale values are never trusted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_o <= '0;
        end else begin
            conv_o.valid     <= go_i;
            conv_o.chan      <= go_i ? chan_i : ~conv_o.chan;
            conv_o.raw       <= go_i ? raw_i : ~conv_o.raw;
            conv_o.open_wire <= go_i ? open_i : ~conv_o.open_wire;
        end
    end
endmodule
`default_nettype wire

// ==== tb/ais_top_tb_top.sv ====
// self-checking bench for the analog input image
`timescale 1ns/1ps
`default_nettype none
module ais_top_tb_top;
    import ais_pkg::*;
    typedef struct packed {logic [3:0] ty; logic [17:0] raw; logic op; logic [15:0] d; logic ov; logic un;} ais_row_t;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic [5:0]       adr = '0;
    logic [31:0]      dat = '0;
    logic             we = 1'b0;
    logic             stb = 1'b0;
    logic             go = 1'b0;
    logic [1:0]       ch = '0;
    logic [17:0]      raw = '0;
    logic             op = 1'b0;
    logic [31:0]      q;
    logic             e;
    logic [31:0]      rdat;
    logic             ack;
    logic             err;
    ais_conv_t        conv;
    ais_chcfg_t [3:0] cfg;
    logic [3:0]       ov = '0;
    logic [3:0]       un = '0;
    logic [15:0]      rng;
    int               fail_count = 0;
    int               checks = 0;
    int               cyc_cnt = 0;
    ais_row_t         rows [8];
    always #2.5 clk_i = ~clk_i;
    ais_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(stb), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .conv_i(conv), .cfg_o(cfg));
    ais_fe u_fe (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .chan_i(ch), .raw_i(raw), .open_i(op), .conv_o(conv));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] i, input logic [15:0] d);
        @(posedge clk_i);
        stb <= 1'b1;
        we  <= w;
        adr <= {i, 2'b00};
        dat <= {16'h0000, d};
        do @(posedge clk_i); while (!(ack || err));
        q = rdat;
        e = err;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic cv(input logic [1:0] c, input logic [17:0] r, input logic o);
        @(posedge clk_i);
        go  <= 1'b1;
        ch  <= c;
        raw <= r;
        op  <= o;
    endtask
    task automatic look(input logic [1:0] c, input logic [15:0] d);
        rng = '0;
        for (int k = 0; k < 4; k++) begin
            rng[15-2*k] = un[k];
            rng[14-2*k] = ov[k];
        end
        wb(1'b0, {2'b00, c}, 16'h0);
        chk("sample", q, {16'h0, d});
        wb(1'b0, 4'h5, 16'h0);
        chk("range", q, {16'h0, rng});
        wb(1'b0, 4'h4, 16'h0);
        chk("error", q, {28'h0, ov | un});
    endtask
    initial begin
        rows = '{'{4'h0, 18'h01234, 1'b0, 16'h1234, 1'b0, 1'b0}, '{4'h1, 18'h08000, 1'b0, 16'h7FFF, 1'b1, 1'b0},
                 '{4'h0, 18'h37FFF, 1'b0, 16'h8000, 1'b0, 1'b1}, '{4'h2, 18'h3E000, 1'b0, 16'hF000, 1'b0, 1'b1},
                 '{4'h3, 18'h00100, 1'b1, 16'hF000, 1'b0, 1'b1}, '{4'h3, 18'h07000, 1'b0, 16'h7000, 1'b0, 1'b0},
                 '{4'h4, 18'h00500, 1'b0, 16'h0500, 1'b0, 1'b0}, '{4'h5, 18'h0A000, 1'b0, 16'h7FFF, 1'b1, 1'b0}};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h8, 16'h0);
        chk("cfg reset", q, 32'h0);
        wb(1'b0, 4'h0, 16'h0);
        chk("sample reset", q, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, {2'b10, i[1:0]}, {4'h8, rows[i].ty, 8'h00});
            cv(i[1:0], rows[i].raw, rows[i].op);
            @(posedge clk_i) go <= 1'b0;
            ov[i[1:0]] = rows[i].ov;
            un[i[1:0]] = rows[i].un;
            look(i[1:0], rows[i].d);
            $display("row %0d done", i);
        end
        wb(1'b0, 4'h7, 16'h0);
        chk("unmapped", {q[31:1], e}, 32'h1);
        wb(1'b1, 4'h0, 16'hABCD);
        wb(1'b0, 4'h0, 16'h0);
        chk("read only", q, 32'h0000F000);
        wb(1'b1, 4'h9, 16'hB305);
        wb(1'b0, 4'h9, 16'h0);
        chk("cfg readback", q, 32'h0000B305);
        $display("access tests done");
        wb(1'b1, 4'h8, 16'h0);
        cv(2'd0, 18'h08000, 1'b0);
        cv(2'd2, 18'h00777, 1'b0);
        cv(2'd3, 18'h3FF00, 1'b0);
        @(posedge clk_i) go <= 1'b0;
        un = 4'b1000;
        ov = 4'b0000;
        look(2'd0, 16'h0000);
        look(2'd2, 16'h0777);
        look(2'd3, 16'hFF00);
        wb(1'b0, 4'h6, 16'h0);
        chk("count", q, 32'h0000000A);
        $display("stream tests done");
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h9, 16'h0);
        chk("cfg after reset", q, 32'h0);
        $display("reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
